//--- include/hie_cfg.svh
// Command codes, field positions, reset values and identity codes
`ifndef HIE_CFG_SVH
`define HIE_CFG_SVH
`define HIE_CMD_MASK_RD 8'h25
`define HIE_CMD_MASK_WR 8'ha5
`define HIE_CMD_ID_RD 8'h27
`define HIE_MASK_RESET 16'h0000
`define HIE_MASK_USED 7'h77
`define HIE_BIT_SOF 0
`define HIE_BIT_ACK_LIST 1
`define HIE_BIT_EOT 2
`define HIE_BIT_OPER 4
`define HIE_BIT_SUSP 5
`define HIE_BIT_CLK 6
`define HIE_GLOBAL_EN_BIT 0
`define HIE_PRODUCT_CODE 8'h5a
`define HIE_REVISION_CODE 8'h01
`endif

//--- include/hie_pkg.sv
// State type shared by the interrupt enable and identity block
package hie_pkg;
    typedef struct packed {
        logic [6:0] mask;
        logic [15:0] rd_data;
        logic rd_valid;
        logic irq;
    } hie_state_s;
endpackage : hie_pkg

//--- design/hie_irq_enable.sv
// Host interrupt enable register, identity register and interrupt request
// Summary of operation
// [RULE1] Enable bits 6:0 map onto status bits
// [RULE2] Global enable qualifies the interrupt request
// [RULE3] All enables clear at power-on
// [RULE4] Enable 1 unmasks, 0 masks source
// [RULE5] Read 25h, write A5h command codes
// [RULE6] Bit 6 gates clock-ready interrupt
// [RULE7] Bit 5 gates host-suspended interrupt
// [RULE8] Bit 4 gates operational-register interrupt
// [RULE9] Bit 2 gates end-of-transfer interrupt
// [RULE10] Bit 1 gates acknowledged-list interrupt
// [RULE11] Bit 0 gates start-of-frame interrupt
// [RULE12] Read-only identity at 27h, product high
// [RULE13] Identity low byte holds revision
// [RULE14] Clock-ready status comes from status register
// [RULE15] End-of-transfer status comes from status register
// [RULE16] Request only when enabled source pending
`include "hie_cfg.svh"
module hie_irq_enable #(
    // Arbitrary identity values
    parameter logic [7:0] PRODUCT_CODE = `HIE_PRODUCT_CODE,
    parameter logic [7:0] REVISION_CODE = `HIE_REVISION_CODE
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic cmd_valid_in,
    input wire logic [7:0] cmd_code_in,
    input wire logic [15:0] wr_data_in,
    input wire logic [15:0] host_irq_status_in,
    input wire logic [15:0] hw_setup_register_in,
    output logic [15:0] rd_data_out,
    output logic rd_valid_out,
    output logic [15:0] host_irq_mask_out,
    output logic host_irq_pin_out
);
    hie_pkg::hie_state_s st_r;
    hie_pkg::hie_state_s st_nxt;
    logic [6:0] gated;
    logic [15:0] mask_word;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.rd_valid = 1'b0;
        mask_word = {9'h000, st_r.mask};
        if (cmd_valid_in && cmd_code_in == `HIE_CMD_MASK_WR) // RULE5
        begin
            st_nxt.mask = wr_data_in[6:0] & `HIE_MASK_USED; // RULE4 RULE16
        end
        if (cmd_valid_in && cmd_code_in == `HIE_CMD_MASK_RD) // RULE5
        begin
            st_nxt.rd_data = mask_word;
            st_nxt.rd_valid = 1'b1;
        end
        if (cmd_valid_in && cmd_code_in == `HIE_CMD_ID_RD) // RULE12
        begin
            st_nxt.rd_data = {PRODUCT_CODE, REVISION_CODE}; // RULE13
            st_nxt.rd_valid = 1'b1;
        end
        // Each status bit 6:0 gated by the enable in the same position; bits 15:7 are ignored
        gated = host_irq_status_in[6:0] & st_r.mask; // RULE1 RULE6 RULE7
        // Bits: clk 6, suspend 5, oper 4, eot 2, ack list 1, sof 0
        // RULE8 RULE9 RULE10 RULE11 RULE14 RULE15
        st_nxt.irq = hw_setup_register_in[`HIE_GLOBAL_EN_BIT]
            && (|gated); // RULE2 RULE16
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            st_r <= '0; // RULE3
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign rd_data_out = st_r.rd_data;
    assign rd_valid_out = st_r.rd_valid;
    assign host_irq_mask_out = {9'h000, st_r.mask};
    assign host_irq_pin_out = st_r.irq;

    // ****************************************************************
    // Checks
    // ****************************************************************
    mask_write_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        cmd_valid_in && cmd_code_in == 8'ha5 |=>
        host_irq_mask_out == {9'h000, $past(wr_data_in[6:0]) & 7'h77})
        else $error("mask write lost"); // RULE5
    mask_read_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        cmd_valid_in && cmd_code_in == 8'h25 |=>
        rd_valid_out && rd_data_out == $past(host_irq_mask_out))
        else $error("mask read wrong"); // RULE5
    id_read_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        cmd_valid_in && cmd_code_in == 8'h27 |=> rd_valid_out &&
        rd_data_out == {PRODUCT_CODE, REVISION_CODE})
        else $error("identity read wrong"); // RULE12
    irq_gate_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        1'b1 |=> host_irq_pin_out == ($past(hw_setup_register_in[0]) &&
        |($past(host_irq_status_in[6:0]) & $past(host_irq_mask_out[6:0]))))
        else $error("irq gating wrong"); // RULE1
    no_global_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        !hw_setup_register_in[0] |=> !host_irq_pin_out)
        else $error("irq without global enable"); // RULE2
    masked_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        host_irq_mask_out == 16'h0000 |=> !host_irq_pin_out)
        else $error("irq while all masked"); // RULE4
    reserved_zero_a: assert property (@(posedge clk_in)
        disable iff (!resetn_in) host_irq_mask_out[15:7] == 9'h000
        && !host_irq_mask_out[3]) else $error("reserved bit set"); // RULE16
    rd_pulse_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        !cmd_valid_in |=> !rd_valid_out)
        else $error("spurious read strobe"); // RULE5
    reset_clear_a: assert property (@(posedge clk_in)
        $rose(resetn_in) |-> host_irq_mask_out == 16'h0000)
        else $error("mask not cleared"); // RULE3
    irq_seen_c: cover property (@(posedge clk_in) $rose(host_irq_pin_out));
    id_read_c: cover property (@(posedge clk_in)
        cmd_valid_in && cmd_code_in == 8'h27);
    wr_rd_c: cover property (@(posedge clk_in) cmd_valid_in &&
        cmd_code_in == 8'ha5 ##1 cmd_valid_in && cmd_code_in == 8'h25);
endmodule : hie_irq_enable

//--- tb/hie_host_model.sv
// Processor model issuing command strobes to the block
module hie_host_model (
    input wire logic clk_in,
    output logic cmd_valid_out,
    output logic [7:0] cmd_code_out,
    output logic [15:0] wr_data_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        cmd_valid_out = 1'b0;
        cmd_code_out = 8'h00;
        wr_data_out = 16'h0000;
    end
    // One command per cycle, changed on the falling edge
    task issue(input logic [7:0] code, input logic [15:0] data);
        @(negedge clk_in);
        cmd_valid_out = 1'b1;
        cmd_code_out = code;
        wr_data_out = data;
    endtask : issue
    // Released data lines show no stale value
    task idle();
        @(negedge clk_in);
        cmd_valid_out = 1'b0;
        wr_data_out = ~wr_data_out;
    endtask : idle
endmodule : hie_host_model

//--- tb/hie_irq_enable_tb_top.sv
// Self-checking bench for the interrupt enable block
`include "hie_cfg.svh"
module hie_irq_enable_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic cmd_valid, rd_valid_out, host_irq_pin_out, e;
    logic [7:0] cmd_code;
    logic [15:0] wr_data, rd_data_out, host_irq_mask_out, w;
    logic [15:0] status = 16'h0000;
    logic [15:0] setup = 16'h0000;
    logic [15:0] exp_q[$];
    logic [6:0] m;
    int errors = 0;
    int total_checks = 0;
    always #50 clk_in = ~clk_in;
    hie_host_model host (.clk_in(clk_in), .cmd_valid_out(cmd_valid),
        .cmd_code_out(cmd_code), .wr_data_out(wr_data));
    hie_irq_enable hie_irq_enable_inst (.clk_in(clk_in),
        .resetn_in(resetn_in), .cmd_valid_in(cmd_valid),
        .cmd_code_in(cmd_code), .wr_data_in(wr_data),
        .host_irq_status_in(status), .hw_setup_register_in(setup),
        .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
        .host_irq_mask_out(host_irq_mask_out),
        .host_irq_pin_out(host_irq_pin_out));
    task check(input logic [15:0] g, input logic [15:0] x);
        total_checks++;
        if (g !== x)
        begin
            errors++;
            $display("BAD %0t got %h exp %h", $time, g, x);
        end
    endtask : check
    task summarize();
        if (errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize
    // Each read answer is matched with the oldest expectation
    always @(posedge clk_in)
        if (rd_valid_out === 1'b1)
            check(rd_data_out, exp_q.size() ? exp_q.pop_front() : 16'hx);
    initial
    begin
        #100000;
        errors++;
        summarize();
    end
    initial
    begin
        void'($urandom(32'hf4ed));
        repeat (4) @(posedge clk_in);
        @(negedge clk_in) resetn_in = 1'b1;
        status = 16'hffff;
        setup = 16'h0001;
        @(negedge clk_in);
        check(host_irq_mask_out, `HIE_MASK_RESET);
        check(16'(host_irq_pin_out), 16'h0000);
        for (int i = 0; i < 16; i++)
        begin
            w = $urandom;
            m = w[6:0] & `HIE_MASK_USED;
            host.issue(`HIE_CMD_MASK_WR, w);
            host.issue(8'h28, ~w);
            exp_q.push_back({9'h000, m});
            host.issue(`HIE_CMD_MASK_RD, 16'h0000);
            exp_q.push_back({`HIE_PRODUCT_CODE, `HIE_REVISION_CODE});
            host.issue(`HIE_CMD_ID_RD, 16'h0000);
            status = i < 7 ? 16'h0001 << i : 16'($urandom);
            setup = 16'($urandom) | 16'(i < 7);
            e = setup[0] & |(status[6:0] & m);
            host.idle();
            @(negedge clk_in);
            check(host_irq_mask_out, {9'h000, m});
            check(16'(host_irq_pin_out), 16'(e));
        end
        repeat (3) @(negedge clk_in);
        check(16'(exp_q.size()), 16'h0000);
        summarize();
    end
endmodule : hie_irq_enable_tb_top
